/* hw/usb_alert_pkg.sv */
// Shared constants and carriers for the NAK and FIFO alert event block
package usb_alert_pkg;

   // Endpoints served per direction and field width per direction
   localparam int NUM_EP   = 3;
   localparam int FIELD_W  = 3;
   localparam int FILL_W   = 6;
   localparam int ADDR_W   = 34;

   // Printed register offsets, kept as word indices
   localparam logic [31:0] NAK_EVENT_IDX  = 32'h5000181c;
   localparam logic [31:0] NAK_MASK_IDX   = 32'h5000181e;
   localparam logic [31:0] FIFO_ALERT_IDX = 32'h50001820;
   localparam logic [31:0] FIFO_MASK_IDX  = 32'h50001822;
   localparam logic [31:0] IRQ_STATUS_IDX = 32'h50001830;
   localparam logic [31:0] IRQ_MASK_IDX   = 32'h50001832;

   // Field positions inside the 16-bit registers
   localparam int IN_NAK_LSB   = 0;
   localparam int OUT_NAK_LSB  = 4;
   localparam int TX_ALERT_LSB = 0;
   localparam int RX_ALERT_LSB = 4;
   localparam int IRQ_NAK_BIT  = 0;
   localparam int IRQ_WARN_BIT = 1;
   localparam int IRQ_W        = 2;

   // Reset values
   localparam logic [15:0] NAK_EVENT_RST  = 16'h0000;
   localparam logic [15:0] NAK_MASK_RST   = 16'h0000;
   localparam logic [15:0] FIFO_ALERT_RST = 16'h0000;
   localparam logic [15:0] FIFO_MASK_RST  = 16'h0000;
   localparam logic [1:0]  IRQ_RST        = 2'h0;

   // Handshake activity reported by the packet engine, one bit per endpoint except the single address enable
   typedef struct packed {
      logic [NUM_EP-1:0] in_nak;
      logic [NUM_EP-1:0] out_nak;
      logic [NUM_EP-1:0] out_overrun;
      logic [NUM_EP-1:0] in_ep_enable;
      logic [NUM_EP-1:0] out_ep_enable;
      logic              address_enable;
   } nak_evt_t;

   // Receive FIFO view for one endpoint
   typedef struct packed {
      logic [FILL_W-1:0] fill;
      logic [FILL_W-1:0] rx_alert_level;
      logic              read;
      logic              flush;
   } rx_fifo_t;

   // Transmit FIFO view for one endpoint
   typedef struct packed {
      logic [FILL_W-1:0] fill;
      logic [FILL_W-1:0] tx_alert_level;
      logic              enable;
      logic              write;
      logic              flush;
      logic              done;
   } tx_fifo_t;

endpackage

/* hw/level_alert_flag.sv */
// One FIFO level alert flag: set on reaching the level, released by events
`timescale 1ns/1ps
module level_alert_flag
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic reached,
   input  wire logic release_evt,
   output logic      flag,
   output logic      raised
);

   logic reached_prev_r;
   logic flag_r;

   // Edge of the level condition, so a held level sets only once
   assign raised = reached & ~reached_prev_r;
   assign flag   = flag_r;

   // Remember the level condition of the last cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reached_prev_r <= 1'b0;
      else
         reached_prev_r <= reached;
   end

   // Setting beats release in the same cycle, no event is lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_r <= 1'b0;
      else if (raised)
         flag_r <= 1'b1;
      else if (release_evt)
         flag_r <= 1'b0;
   end

endmodule // level_alert_flag

/* hw/usb_nak_fifo_alerts.sv */
// NAK and FIFO level alert event registers with APB access and summaries
//
// Operation
// - An IN NAK sets the IN flag of its endpoint when address and endpoint are enabled.
// - Reading the NAK event register clears the IN and OUT NAK flags it returned.
// - An unmasked set NAK flag drives the NAK summary bit high.
// - A NAK flag whose mask bit is zero has no effect on the NAK summary.
// - A receive FIFO reaching its alert level sets its receive alert flag.
// - A receive alert flag clears when the FIFO is read out or flushed.
// - A transmit FIFO reaching its alert level while enabled sets its flag.
// - A transmit alert flag clears on a FIFO write, a flush or transmit done.
// - An unmasked set FIFO alert flag drives the WARN summary bit high.
// - A FIFO alert flag whose mask bit is zero has no effect on WARN.
// - An OUT NAK sets the OUT flag of its endpoint when address and endpoint are enabled.
// - An OUT NAK caused by a receive overrun sets no OUT flag.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module usb_nak_fifo_alerts
   import usb_alert_pkg::*;
#(
   parameter int N_EP = NUM_EP
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire nak_evt_t          nak_evt,
   input  wire rx_fifo_t          rx_fifo [N_EP],
   input  wire tx_fifo_t          tx_fifo [N_EP],
   output logic                   nak_summary,
   output logic                   warn_summary,
   output logic                   irq
);

   // The register layout holds exactly three endpoints per field
   generate
      if (N_EP != FIELD_W)
      begin : g_bad_ep
         $error("N_EP must equal the register field width");
      end
   endgenerate

   // Bus state
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [31:0]       word_idx;
   logic              setup_ph;
   logic              wr_take;
   logic              rd_take;
   logic              addr_hit;
   logic [31:0]       rdata_nxt;

   // Event and mask storage
   logic [N_EP-1:0]   in_nak_flags_r;
   logic [N_EP-1:0]   out_nak_flags_r;
   logic [N_EP-1:0]   in_nak_enables_r;
   logic [N_EP-1:0]   out_nak_enables_r;
   logic [N_EP-1:0]   rx_level_alert_enables_r;
   logic [N_EP-1:0]   tx_level_alert_enables_r;
   logic [N_EP-1:0]   rx_level_alert_flags;
   logic [N_EP-1:0]   tx_level_alert_flags;
   logic [N_EP-1:0]   rx_raised;
   logic [N_EP-1:0]   tx_raised;

   // Handshake set terms
   logic [N_EP-1:0]   in_nak_set;
   logic [N_EP-1:0]   out_nak_set;
   logic [N_EP-1:0]   in_nak_nxt;
   logic [N_EP-1:0]   out_nak_nxt;
   logic [N_EP-1:0]   in_nak_rd_clr;
   logic [N_EP-1:0]   out_nak_rd_clr;

   // Interrupt state
   logic [IRQ_W-1:0]  irq_status_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic [IRQ_W-1:0]  irq_events;
   logic [IRQ_W-1:0]  irq_rd_clr;
   logic [IRQ_W-1:0]  irq_status_nxt;

   // Summary flops
   logic              nak_summary_r;
   logic              warn_summary_r;
   logic              irq_r;

   // Outputs come straight from flops
   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   assign nak_summary  = nak_summary_r;
   assign warn_summary = warn_summary_r;
   assign irq          = irq_r;

   // Bus phase decode; word index is the byte address over four
   assign word_idx = paddr[ADDR_W-1:2];
   assign setup_ph = psel & ~penable;
   assign wr_take  = psel & penable & pready_r & pwrite;
   assign rd_take  = psel & penable & pready_r & ~pwrite;

   // Address hit, used only by the error answer; the read mux decodes word_idx itself
   always_comb
   begin
      unique case (word_idx)
         NAK_EVENT_IDX,
         NAK_MASK_IDX,
         FIFO_ALERT_IDX,
         FIFO_MASK_IDX,
         IRQ_STATUS_IDX,
         IRQ_MASK_IDX:
            addr_hit = 1'b1;
         default:
            addr_hit = 1'b0;
      endcase
   end

   // Read mux; reserved bits and upper half read as zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      unique case (word_idx)
         NAK_EVENT_IDX:
         begin
            rdata_nxt[IN_NAK_LSB +: FIELD_W]  = in_nak_flags_r;
            rdata_nxt[OUT_NAK_LSB +: FIELD_W] = out_nak_flags_r;
         end
         NAK_MASK_IDX:
         begin
            rdata_nxt[IN_NAK_LSB +: FIELD_W]  = in_nak_enables_r;
            rdata_nxt[OUT_NAK_LSB +: FIELD_W] = out_nak_enables_r;
         end
         FIFO_ALERT_IDX:
         begin
            rdata_nxt[TX_ALERT_LSB +: FIELD_W] = tx_level_alert_flags;
            rdata_nxt[RX_ALERT_LSB +: FIELD_W] = rx_level_alert_flags;
         end
         FIFO_MASK_IDX:
         begin
            rdata_nxt[TX_ALERT_LSB +: FIELD_W] = tx_level_alert_enables_r;
            rdata_nxt[RX_ALERT_LSB +: FIELD_W] = rx_level_alert_enables_r;
         end
         IRQ_STATUS_IDX:
            rdata_nxt[IRQ_W-1:0] = irq_status_r;
         IRQ_MASK_IDX:
            rdata_nxt[IRQ_W-1:0] = irq_mask_r;
         default:
            rdata_nxt = 32'h0000_0000;
      endcase
   end

   // No wait state: ready rises for the first access cycle only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_r <= 1'b0;
      else
         pready_r <= setup_ph & ~pready_r;
   end

   // Data and error are captured in the setup cycle and held to the end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
         pslverr_r <= ~addr_hit;
      end
      else if (!psel)
      begin
         pslverr_r <= 1'b0;
      end
   end

   // NAK mask register, only the endpoint bits are stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_nak_enables_r  <= NAK_MASK_RST[IN_NAK_LSB +: FIELD_W];
         out_nak_enables_r <= NAK_MASK_RST[OUT_NAK_LSB +: FIELD_W];
      end
      else if (wr_take && word_idx == NAK_MASK_IDX)
      begin
         in_nak_enables_r  <= pwdata[IN_NAK_LSB +: FIELD_W];
         out_nak_enables_r <= pwdata[OUT_NAK_LSB +: FIELD_W];
      end
   end

   // FIFO alert mask register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_level_alert_enables_r <= FIFO_MASK_RST[TX_ALERT_LSB +: FIELD_W];
         rx_level_alert_enables_r <= FIFO_MASK_RST[RX_ALERT_LSB +: FIELD_W];
      end
      else if (wr_take && word_idx == FIFO_MASK_IDX)
      begin
         tx_level_alert_enables_r <= pwdata[TX_ALERT_LSB +: FIELD_W];
         rx_level_alert_enables_r <= pwdata[RX_ALERT_LSB +: FIELD_W];
      end
   end

   // Interrupt mask register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_r <= IRQ_RST;
      else if (wr_take && word_idx == IRQ_MASK_IDX)
         irq_mask_r <= pwdata[IRQ_W-1:0];
   end

   assign in_nak_set = nak_evt.in_nak & nak_evt.in_ep_enable
                     & {N_EP{nak_evt.address_enable}};

   assign out_nak_set = nak_evt.out_nak & nak_evt.out_ep_enable
                      & ~nak_evt.out_overrun
                      & {N_EP{nak_evt.address_enable}};

   // clear on read
   // Only bits that were returned are cleared, so a NAK landing after
   // the setup cycle stays pending for the next read.
   always_comb
   begin
      in_nak_rd_clr  = '0;
      out_nak_rd_clr = '0;
      if (rd_take && word_idx == NAK_EVENT_IDX)
      begin
         in_nak_rd_clr  = prdata_r[IN_NAK_LSB +: FIELD_W];
         out_nak_rd_clr = prdata_r[OUT_NAK_LSB +: FIELD_W];
      end
   end

   // Set wins over read clear
   assign in_nak_nxt  = (in_nak_flags_r & ~in_nak_rd_clr) | in_nak_set;
   assign out_nak_nxt = (out_nak_flags_r & ~out_nak_rd_clr) | out_nak_set;

   // NAK event flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_nak_flags_r  <= NAK_EVENT_RST[IN_NAK_LSB +: FIELD_W];
         out_nak_flags_r <= NAK_EVENT_RST[OUT_NAK_LSB +: FIELD_W];
      end
      else
      begin
         in_nak_flags_r  <= in_nak_nxt;
         out_nak_flags_r <= out_nak_nxt;
      end
   end

   // Per-endpoint FIFO level alert flags
   generate
      for (genvar ep = 0; ep < N_EP; ep++)
      begin : g_ep
         logic rx_reached;
         logic tx_reached;
         logic rx_release;
         logic tx_release;

         assign rx_reached = rx_fifo[ep].fill >= rx_fifo[ep].rx_alert_level;
         assign rx_release = rx_fifo[ep].read | rx_fifo[ep].flush;

         assign tx_reached = tx_fifo[ep].enable
                           & (tx_fifo[ep].fill <= tx_fifo[ep].tx_alert_level);
         assign tx_release = tx_fifo[ep].write | tx_fifo[ep].flush
                           | tx_fifo[ep].done;

         level_alert_flag u_rx_flag
         (
            .pclk        (pclk),
            .presetn     (presetn),
            .reached     (rx_reached),
            .release_evt (rx_release),
            .flag        (rx_level_alert_flags[ep]),
            .raised      (rx_raised[ep])
         );

         level_alert_flag u_tx_flag
         (
            .pclk        (pclk),
            .presetn     (presetn),
            .reached     (tx_reached),
            .release_evt (tx_release),
            .flag        (tx_level_alert_flags[ep]),
            .raised      (tx_raised[ep])
         );
      end
   endgenerate

   // Summary bits follow flag or mask changes alike, one cycle behind
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nak_summary_r  <= 1'b0;
         warn_summary_r <= 1'b0;
      end
      else
      begin
         nak_summary_r  <= |(in_nak_flags_r & in_nak_enables_r)
                         | |(out_nak_flags_r & out_nak_enables_r);
         warn_summary_r <= |(rx_level_alert_flags & rx_level_alert_enables_r)
                         | |(tx_level_alert_flags & tx_level_alert_enables_r);
      end
   end

   // Interrupt events: any new NAK flag, any new level alert
   assign irq_events[IRQ_NAK_BIT]  = |in_nak_set | |out_nak_set;
   assign irq_events[IRQ_WARN_BIT] = |rx_raised | |tx_raised;

   // Read clears only the status bits it returned
   assign irq_rd_clr = (rd_take && word_idx == IRQ_STATUS_IDX)
                     ? prdata_r[IRQ_W-1:0] : IRQ_RST;
   assign irq_status_nxt = (irq_status_r & ~irq_rd_clr) | irq_events;

   // Sticky interrupt status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_r <= IRQ_RST;
      else
         irq_status_r <= irq_status_nxt;
   end

   // Level interrupt, high while an unmasked status bit is set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(irq_status_nxt & irq_mask_r);
   end

endmodule // usb_nak_fifo_alerts

/* verif/usb_alert_chk_asserts.sv */
// Port-level checker for the NAK and FIFO alert event block
`timescale 1ns/1ps
module usb_alert_chk
   import usb_alert_pkg::*;
#(
   parameter int N_EP = NUM_EP
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire nak_evt_t          nak_evt,
   input wire rx_fifo_t          rx_fifo [N_EP],
   input wire tx_fifo_t          tx_fifo [N_EP],
   input wire logic              nak_summary,
   input wire logic              warn_summary,
   input wire logic              irq
);
   logic        map_w;
   logic        acc_w;
   logic        nak_src_w;
   logic        warn_src_w;
   logic [31:0] idx_w;
   // Decode and causes; any finished access may move a mask or clear flags
   assign idx_w = paddr[ADDR_W-1:2];
   assign map_w = idx_w inside {NAK_EVENT_IDX, NAK_MASK_IDX, FIFO_ALERT_IDX,
                                FIFO_MASK_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX};
   assign acc_w = psel & penable & pready;
   assign nak_src_w = acc_w | (nak_evt.address_enable &
      |((nak_evt.in_nak & nak_evt.in_ep_enable) |
        (nak_evt.out_nak & nak_evt.out_ep_enable & ~nak_evt.out_overrun)));
   // Release pulses of all alert flags
   always_comb
   begin
      warn_src_w = acc_w;
      for (int i = 0; i < N_EP; i++)
      begin
         warn_src_w |= rx_fifo[i].read | rx_fifo[i].flush | tx_fifo[i].write
                       | tx_fifo[i].flush | tx_fifo[i].done;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_unmapped_a: assert property (psel && !penable && !map_w
      |=> pslverr && pready) else $error("unmapped access not refused");
   ok_mapped_a: assert property (psel && !penable && map_w |=> !pslverr)
      else $error("mapped access refused");
   rdata_hold_a: assert property (acc_w |=> $stable(prdata))
      else $error("read data moved after access");
   nak_rise_a: assert property ($rose(nak_summary) |->
      $past(nak_src_w, 1) || $past(nak_src_w, 2) || $past(nak_src_w, 3))
      else $error("nak summary rose without cause");
   nak_fall_a: assert property ($fell(nak_summary) |->
      $past(acc_w, 1) || $past(acc_w, 2) || $past(acc_w, 3))
      else $error("nak summary fell without access");
   warn_fall_a: assert property ($fell(warn_summary) |->
      $past(warn_src_w, 1) || $past(warn_src_w, 2) || $past(warn_src_w, 3))
      else $error("warn summary fell without release");
   irq_fall_a: assert property ($fell(irq) |->
      $past(acc_w, 1) || $past(acc_w, 2) || $past(acc_w, 3))
      else $error("irq fell without access");
endmodule // usb_alert_chk

bind usb_nak_fifo_alerts usb_alert_chk #(.N_EP(N_EP)) chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .nak_evt, .rx_fifo, .tx_fifo, .nak_summary, .warn_summary, .irq);

/* verif/usb_host_model.sv */
// Host side model raising NAK handshake pulses toward the event block
`timescale 1ns/1ps
module usb_host_model
   import usb_alert_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       req,
   input  wire logic [1:0] kind,
   input  wire logic [1:0] ep,
   input  wire logic       addr_en,
   output nak_evt_t        nak_evt
);
   // One pulse per request; kind 0 IN, 1 OUT, 2 OUT lost to overrun,
   // 3 IN toward an endpoint that is switched off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nak_evt <= '0;
      end
      else
      begin
         nak_evt.in_nak         <= (req && (kind == 2'd0 || kind == 2'd3))
                                   ? 3'h1 << ep : 3'h0;
         nak_evt.out_nak        <= (req && (kind == 2'd1 || kind == 2'd2))
                                   ? 3'h1 << ep : 3'h0;
         nak_evt.out_overrun    <= (req && kind == 2'd2) ? 3'h1 << ep : 3'h0;
         nak_evt.in_ep_enable   <= (req && kind == 2'd3)
                                   ? ~(3'h1 << ep) : 3'h7;
         nak_evt.out_ep_enable  <= 3'h7;
         nak_evt.address_enable <= addr_en;
      end
   end
endmodule // usb_host_model

/* verif/usb_nak_fifo_warning_events_tb.sv */
// Self-checking bench for the NAK and FIFO alert event block
`timescale 1ns/1ps
module usb_nak_fifo_warning_events_tb;
   import usb_alert_pkg::*;
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("wrong value at %0t: got %h want %h", $time, got, exp); \
      end \
   end
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   nak_evt_t          nak_evt;
   rx_fifo_t          rx_f [NUM_EP];
   tx_fifo_t          tx_f [NUM_EP];
   logic              nak_summary;
   logic              warn_summary;
   logic              irq;
   logic              req;
   logic [1:0]        kind;
   logic [1:0]        ep;
   logic              addr_en;
   int                n_fail;
   int                checks_done;
   int                cycles;
   usb_host_model host_m (.pclk, .presetn, .req, .kind, .ep, .addr_en,
                          .nak_evt);
   usb_nak_fifo_alerts #(.N_EP(NUM_EP)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .nak_evt, .rx_fifo(rx_f), .tx_fifo(tx_f), .nak_summary,
      .warn_summary, .irq);
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Master holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [31:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No own limit: only the hang guard may end this wait
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      apb(1'b1, idx, wd, d, e);
   endtask
   task automatic rchk(input logic [31:0] idx, input logic [15:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'b0, idx, 32'h0, d, e);
      `CHK(d[15:0], exp)
   endtask
   // Host pulse, then time for flag and summary to settle
   task automatic host(input logic [1:0] k, input logic [1:0] e,
                       input logic a);
      @(posedge pclk);
      req     <= 1'b1;
      kind    <= k;
      ep      <= e;
      addr_en <= a;
      @(posedge pclk);
      req     <= 1'b0;
      step(4);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic        e;
      rchk(NAK_EVENT_IDX, NAK_EVENT_RST);
      rchk(NAK_MASK_IDX, NAK_MASK_RST);
      rchk(FIFO_ALERT_IDX, FIFO_ALERT_RST);
      rchk(FIFO_MASK_IDX, FIFO_MASK_RST);
      wr(FIFO_ALERT_IDX, 32'h00000011);
      rchk(FIFO_ALERT_IDX, 16'h0000);
      apb(1'b0, 32'h00000100, 32'h0, d, e);
      `CHK(e, 1'b1)
      wr(NAK_MASK_IDX, 32'h00000077);
      rchk(NAK_MASK_IDX, 16'h0077);
   endtask
   task automatic t_nak();
      host(2'd0, 2'd0, 1'b1);
      `CHK(nak_summary, 1'b1)
      rchk(NAK_EVENT_IDX, 16'h0001);
      rchk(NAK_EVENT_IDX, 16'h0000);
      host(2'd2, 2'd1, 1'b1);
      rchk(NAK_EVENT_IDX, 16'h0000);
      host(2'd1, 2'd2, 1'b1);
      rchk(NAK_EVENT_IDX, 16'h0040);
      host(2'd0, 2'd1, 1'b0);
      rchk(NAK_EVENT_IDX, 16'h0000);
      host(2'd3, 2'd0, 1'b1);
      rchk(NAK_EVENT_IDX, 16'h0000);
      wr(NAK_MASK_IDX, 32'h0);
      host(2'd0, 2'd2, 1'b1);
      `CHK(nak_summary, 1'b0)
      wr(NAK_MASK_IDX, 32'h00000004);
      step(3);
      `CHK(nak_summary, 1'b1)
      rchk(NAK_EVENT_IDX, 16'h0004);
      step(3);
      `CHK(nak_summary, 1'b0)
   endtask
   task automatic t_irq();
      wr(IRQ_MASK_IDX, 32'h00000003);
      rchk(IRQ_STATUS_IDX, 16'h0001);
      host(2'd0, 2'd0, 1'b1);
      `CHK(irq, 1'b1)
      rchk(IRQ_STATUS_IDX, 16'h0001);
      step(2);
      `CHK(irq, 1'b0)
   endtask
   // Flags re-arm only after the level falls, so each pass toggles it
   task automatic t_alert();
      for (int k = 0; k < 2; k++)
      begin
         wr(FIFO_MASK_IDX, k ? 32'h00000010 : 32'h0);
         rx_f[0].fill <= 6'h04;
         step(3);
         rchk(FIFO_ALERT_IDX, 16'h0010);
         `CHK(warn_summary, k[0])
         rx_f[0].read  <= (k == 0);
         rx_f[0].flush <= (k == 1);
         rx_f[0].fill  <= 6'h03;
         @(posedge pclk);
         rx_f[0].read  <= 1'b0;
         rx_f[0].flush <= 1'b0;
         step(3);
         rchk(FIFO_ALERT_IDX, 16'h0000);
      end
      for (int k = 0; k < 3; k++)
      begin
         tx_f[1].enable <= 1'b1;
         tx_f[1].fill   <= 6'h0a;
         step(2);
         tx_f[1].fill   <= 6'h02;
         step(3);
         rchk(FIFO_ALERT_IDX, 16'h0002);
         tx_f[1].write <= (k == 0);
         tx_f[1].flush <= (k == 1);
         tx_f[1].done  <= (k == 2);
         @(posedge pclk);
         tx_f[1].write <= 1'b0;
         tx_f[1].flush <= 1'b0;
         tx_f[1].done  <= 1'b0;
         step(3);
         rchk(FIFO_ALERT_IDX, 16'h0000);
      end
   endtask
   // Inputs quiet at time zero; alert levels out of reach until used
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {req, kind, ep, addr_en} = '0;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      for (int i = 0; i < NUM_EP; i++)
      begin
         rx_f[i] = '{fill: 6'h00, rx_alert_level: 6'h04, default: 1'b0};
         tx_f[i] = '{fill: 6'h3f, tx_alert_level: 6'h02, default: 1'b0};
      end
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_nak();
      t_irq();
      t_alert();
      wrap_up();
   end
endmodule // usb_nak_fifo_warning_events_tb
